// ==== rtl/mbps_slave.sv ====
/*
  Parameter-access slave: frames requests by idle gap, checks CRC and
  address, runs one parameter access and sends the answer frame.
  Assumes a parameter store on the user side that acknowledges each
  request with data and an error code (zero means success).
*/
// Summary of operation
// - frames bounded by 3.5 character idle gaps
// - failed request answered with command plus 0x80
// - error codes 1 command, 2 address, 3 data, 4 fault
// - read answer: address, command, byte count, values
// - start address is group high, offset low
// - single write answered by echoing the request
// - 32-bit parameter: lower offset, two words, atomic
// - word order setting picks low or high first
// - 32-bit write: command 0x10, two words, four bytes
// - CRC-16 preset FFFF, poly A001, low byte first
// - both ends same CRC; mismatch is an error
// - signed 16-bit values in two's complement
// - signed 32-bit values in two's complement
// - act on own axis address; answers carry it
// - axis address range 1 to 247
// - 0x06 only 16-bit, 0x10 only 32-bit
`include "mbps_map.svh"
`default_nettype none
module mbps_slave
  import mbps_pkg::*;
#(
  parameter int CHAR_CYC = `MBPS_CHAR_CYC
)(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // link to host
  mbps_link_if.slave       lnk,
  // configuration
  input  wire logic [7:0]  axis_addr_i,
  input  wire logic        word_order_select_i,
  // parameter store
  output logic             param_req_o,
  output logic             param_we_o,
  output logic             param_wide_o,
  output logic [15:0]      param_addr_o,
  output logic [31:0]      param_wdata_o,
  input  wire logic        param_ack_i,
  input  wire logic [31:0] param_rdata_i,
  input  wire logic [7:0]  param_status_i
);
  // --------------------------------------------------------------------
  // timing
  // --------------------------------------------------------------------
  localparam int GAP_CYC = (CHAR_CYC * `MBPS_GAP_HALFCHARS + 1) / 2;
  localparam logic [15:0] GAP16 = 16'(GAP_CYC);
  localparam logic [15:0] CHAR16 = 16'(CHAR_CYC);

  generate
    if (CHAR_CYC < 2 || GAP_CYC > 65535)
    begin : g_bad
      $error("CHAR_CYC out of range");
    end
  endgenerate

  // --------------------------------------------------------------------
  // state and request decode
  // --------------------------------------------------------------------
  mbps_slv_s r;
  mbps_slv_s n;
  logic [7:0]  rq_cmd;
  logic [15:0] rq_cnt;
  logic        addr_ok;
  logic [7:0]  chk_err;
  logic [15:0] w_first;
  logic [15:0] w_second;
  logic [15:0] rd_first;
  logic [15:0] rd_second;

  assign rq_cmd   = r.rx[1];
  assign rq_cnt   = {r.rx[4], r.rx[5]};
  assign w_first  = {r.rx[7], r.rx[8]};
  assign w_second = {r.rx[9], r.rx[10]};
  // own address must also lie in the legal range
  assign addr_ok  = (r.rx[0] == axis_addr_i) && (axis_addr_i >= `MBPS_ADDR_MIN) &&
                    (axis_addr_i <= `MBPS_ADDR_MAX);

  // data checks; wrong length or count is an illegal-data answer
  always_comb
  begin
    chk_err = `MBPS_ERR_NONE;
    if (rq_cmd == `MBPS_CMD_READ)
    begin
      if (r.rx_n != `MBPS_LEN_SHORT || (rq_cnt != `MBPS_RD_ONE && rq_cnt != `MBPS_W32_WORDS))
        chk_err = `MBPS_ERR_DATA;
    end
    else if (rq_cmd == `MBPS_CMD_WR16)
    begin
      if (r.rx_n != `MBPS_LEN_SHORT)
        chk_err = `MBPS_ERR_DATA;
    end
    else if (rq_cmd == `MBPS_CMD_WR32)
    begin
      if (r.rx_n != `MBPS_LEN_W32 || rq_cnt != `MBPS_W32_WORDS || r.rx[6] != `MBPS_W32_BYTES)
        chk_err = `MBPS_ERR_DATA;
    end
    else
      chk_err = `MBPS_ERR_CMD;
  end

  // read data in wire order; wide values split by the order setting
  assign rd_first  = word_order_select_i ? param_rdata_i[15:0] : param_rdata_i[31:16];
  assign rd_second = word_order_select_i ? param_rdata_i[31:16] : param_rdata_i[15:0];

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  // start an answer frame from the first tx_n bytes of tx
  function automatic mbps_slv_s start_tx(input mbps_slv_s s, input logic [3:0] len);
    mbps_slv_s t;
    t = s;
    t.tx_n = len;
    t.tx_i = 4'h0;
    t.tick = 16'h0000;
    t.crc  = `MBPS_CRC_INIT;
    t.st   = MBPS_S_TX;
    return t;
  endfunction

  // drop the frame and listen again
  function automatic mbps_slv_s rearm(input mbps_slv_s s);
    mbps_slv_s t;
    t = s;
    t.rx_n = 5'h00;
    t.ovf  = 1'b0;
    t.crc  = `MBPS_CRC_INIT;
    t.st   = MBPS_S_RX;
    return t;
  endfunction

  // --------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------
  always_comb
  begin
    n = r;
    n.s2m_v = 1'b0;
    // idle time since the last request byte
    if (lnk.m2s_valid)
      n.gap = 16'h0000;
    else if (r.gap != GAP16)
      n.gap = r.gap + 16'h0001;
    case (r.st)
      MBPS_S_RX:
      begin
        if (lnk.m2s_valid)
        begin
          if (r.rx_n[4])
            n.ovf = 1'b1;
          else
          begin
            n.rx[r.rx_n[3:0]] = lnk.m2s_data;
            n.rx_n = r.rx_n + 5'h01;
          end
          n.crc = mbps_crc_step(r.crc, lnk.m2s_data);
        end
        else if (r.gap == GAP16 && r.rx_n != 5'h00)
          n.st = MBPS_S_CHK;
      end
      MBPS_S_CHK:
      begin
        n.cmd     = rq_cmd;
        n.p_addr  = {r.rx[2], r.rx[3]};
        n.p_we    = (rq_cmd != `MBPS_CMD_READ);
        n.p_wide  = (rq_cmd == `MBPS_CMD_WR32) || (rq_cmd == `MBPS_CMD_READ && rq_cnt == `MBPS_W32_WORDS);
        // signed values pass as raw two's complement bits
        if (rq_cmd == `MBPS_CMD_WR32)
          n.p_wdata = word_order_select_i ? {w_second, w_first} : {w_first, w_second};
        else
          n.p_wdata = {16'h0000, rq_cnt};
        // residue of a frame with its own CRC appended is zero
        if (r.crc != 16'h0000 || r.rx_n < 5'h04 || r.ovf || !addr_ok)
          n = rearm(n);
        else if (chk_err != `MBPS_ERR_NONE)
        begin
          n.tx[0] = axis_addr_i;
          n.tx[1] = rq_cmd | `MBPS_EXC_BIT;
          n.tx[2] = chk_err;
          n = start_tx(n, 4'h3);
        end
        else
          n.st = MBPS_S_ACC;
      end
      MBPS_S_ACC:
      begin
        if (param_ack_i)
        begin
          n.tx[0] = axis_addr_i;
          if (param_status_i != `MBPS_ERR_NONE)
          begin
            n.tx[1] = r.cmd | `MBPS_EXC_BIT;
            n.tx[2] = param_status_i;
            n = start_tx(n, 4'h3);
          end
          else if (r.cmd == `MBPS_CMD_READ)
          begin
            n.tx[1] = r.cmd;
            if (r.p_wide)
            begin
              n.tx[2] = 8'h04;
              n.tx[3] = rd_first[15:8];
              n.tx[4] = rd_first[7:0];
              n.tx[5] = rd_second[15:8];
              n.tx[6] = rd_second[7:0];
              n = start_tx(n, 4'h7);
            end
            else
            begin
              n.tx[2] = 8'h02;
              n.tx[3] = param_rdata_i[15:8];
              n.tx[4] = param_rdata_i[7:0];
              n = start_tx(n, 4'h5);
            end
          end
          else
          begin
            // echo of command, address and value or count
            n.tx[1] = r.cmd;
            n.tx[2] = r.rx[2];
            n.tx[3] = r.rx[3];
            n.tx[4] = r.rx[4];
            n.tx[5] = r.rx[5];
            n = start_tx(n, 4'h6);
          end
        end
      end
      MBPS_S_TX:
      begin
        // one byte per character time keeps bytes inside the frame gap
        if (r.tick != 16'h0000)
          n.tick = r.tick - 16'h0001;
        else
        begin
          n.tick  = CHAR16 - 16'h0001;
          n.s2m_v = 1'b1;
          n.tx_i  = r.tx_i + 4'h1;
          if (r.tx_i < r.tx_n)
          begin
            n.s2m_d = r.tx[r.tx_i[2:0]];
            n.crc   = mbps_crc_step(r.crc, r.tx[r.tx_i[2:0]]);
          end
          else if (r.tx_i == r.tx_n)
            n.s2m_d = r.crc[7:0];
          else
          begin
            n.s2m_d = r.crc[15:8];
            n.gap   = 16'h0000;
            n = rearm(n);
          end
        end
      end
      default:
        n = rearm(n);
    endcase
  end

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      r <= '0;
      r.st <= MBPS_S_RX;
      r.crc <= `MBPS_CRC_INIT;
    end
    else
      r <= n;
  end

  // --------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------
  assign lnk.s2m_valid  = r.s2m_v;
  assign lnk.s2m_data   = r.s2m_d;
  assign param_req_o    = (r.st == MBPS_S_ACC);
  assign param_we_o     = r.p_we;
  assign param_wide_o   = r.p_wide;
  assign param_addr_o   = r.p_addr;
  assign param_wdata_o  = r.p_wdata;
endmodule
`default_nettype wire

// ==== rtl/mbps_map.svh ====
/*
  Constants of the parameter-access link: command codes, error codes,
  CRC figures, frame lengths and gap timing.
  Assumes inclusion by bare name; holds definitions only.
*/
`ifndef MBPS_MAP_SVH
`define MBPS_MAP_SVH
// --------------------------------------------------------------------
// command and error codes
// --------------------------------------------------------------------
`define MBPS_CMD_READ   8'h03
`define MBPS_CMD_WR16   8'h06
`define MBPS_CMD_WR32   8'h10
`define MBPS_EXC_BIT    8'h80
`define MBPS_ERR_NONE   8'h00
`define MBPS_ERR_CMD    8'h01
`define MBPS_ERR_ADDR   8'h02
`define MBPS_ERR_DATA   8'h03
`define MBPS_ERR_FAULT  8'h04
// --------------------------------------------------------------------
// frame check and layout
// --------------------------------------------------------------------
`define MBPS_CRC_INIT   16'hFFFF
`define MBPS_CRC_POLY   16'hA001
`define MBPS_ADDR_MIN   8'h01
`define MBPS_ADDR_MAX   8'hF7
`define MBPS_LEN_SHORT  5'h08
`define MBPS_LEN_W32    5'h0D
`define MBPS_W32_WORDS  16'h0002
`define MBPS_W32_BYTES  8'h04
`define MBPS_RD_ONE     16'h0001
// --------------------------------------------------------------------
// timing: gap in half characters, character in clock cycles
// --------------------------------------------------------------------
`define MBPS_GAP_HALFCHARS 7
`define MBPS_CHAR_CYC      16
`define MBPS_RSP_TIMEOUT   8000
`endif

// ==== rtl/mbps_pkg.sv ====
/*
  Types and the shared CRC step of the parameter-access link.
  Assumes mbps_map.svh is on the include path.
*/
`include "mbps_map.svh"
`default_nettype none
package mbps_pkg;
  // ------------------------------------------------------------------
  // states
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    MBPS_S_RX  = 4'h1,
    MBPS_S_CHK = 4'h2,
    MBPS_S_ACC = 4'h4,
    MBPS_S_TX  = 4'h8
  } mbps_sst_e;

  typedef enum logic [2:0] {
    MBPS_M_IDLE = 3'h1,
    MBPS_M_TX   = 3'h2,
    MBPS_M_RX   = 3'h4
  } mbps_mst_e;

  // ------------------------------------------------------------------
  // state records
  // ------------------------------------------------------------------
  typedef struct packed {
    mbps_sst_e        st;
    logic [15:0][7:0] rx;
    logic [4:0]       rx_n;
    logic             ovf;
    logic [15:0]      crc;
    logic [15:0]      gap;
    logic [15:0]      tick;
    logic [6:0][7:0]  tx;
    logic [3:0]       tx_n;
    logic [3:0]       tx_i;
    logic [7:0]       cmd;
    logic [15:0]      p_addr;
    logic [31:0]      p_wdata;
    logic             p_we;
    logic             p_wide;
    logic             s2m_v;
    logic [7:0]       s2m_d;
  } mbps_slv_s;

  typedef struct packed {
    mbps_mst_e        st;
    logic [10:0][7:0] tx;
    logic [3:0]       tx_n;
    logic [3:0]       tx_i;
    logic [8:0][7:0]  rx;
    logic [3:0]       rx_n;
    logic [15:0]      crc;
    logic [15:0]      gap;
    logic [15:0]      tick;
    logic [15:0]      tmo;
    logic             order;
    logic [7:0]       cmd;
    logic             done;
    logic             ok;
    logic             exc;
    logic [7:0]       exc_code;
    logic             crc_err;
    logic             timeout;
    logic [31:0]      rdata;
    logic             m2s_v;
    logic [7:0]       m2s_d;
  } mbps_mst_s;

  // one byte through the reflected CRC-16
  function automatic logic [15:0] mbps_crc_step(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc ^ {8'h00, data};
    for (int i = 0; i < 8; i++)
    begin
      c = c[0] ? ((c >> 1) ^ `MBPS_CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction
endpackage
`default_nettype wire

// ==== rtl/mbps_link_if.sv ====
/*
  Byte link between host controller and parameter slave.
  Assumes one shared clock; a byte is one cycle of valid.
*/
`default_nettype none
interface mbps_link_if;
  // request bytes, host to slave
  logic       m2s_valid;
  logic [7:0] m2s_data;
  // answer bytes, slave to host
  logic       s2m_valid;
  logic [7:0] s2m_data;

  modport master (output m2s_valid, output m2s_data, input s2m_valid, input s2m_data);
  modport slave  (input m2s_valid, input m2s_data, output s2m_valid, output s2m_data);
endinterface
`default_nettype wire

// ==== rtl/mbps_master.sv ====
/*
  Host-controller end: builds one request frame, sends it after an idle
  gap, collects the answer, checks it and reports the result.
  Assumes one request at a time from the user side.
*/
`include "mbps_map.svh"
`default_nettype none
module mbps_master
  import mbps_pkg::*;
#(
  parameter int CHAR_CYC    = `MBPS_CHAR_CYC,
  parameter int RSP_TIMEOUT = `MBPS_RSP_TIMEOUT
)(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // link to slave
  mbps_link_if.master      lnk,
  // request
  input  wire logic        req_i,
  input  wire logic [7:0]  cmd_i,
  input  wire logic [7:0]  axis_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [15:0] count_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        word_order_select_i,
  output logic             ready_o,
  // result
  output logic             done_o,
  output logic             ok_o,
  output logic             exc_o,
  output logic [7:0]       exc_code_o,
  output logic             crc_err_o,
  output logic             timeout_o,
  output logic [31:0]      rdata_o
);
  // --------------------------------------------------------------------
  // timing
  // --------------------------------------------------------------------
  localparam int GAP_CYC = (CHAR_CYC * `MBPS_GAP_HALFCHARS + 1) / 2;
  localparam logic [15:0] GAP16 = 16'(GAP_CYC);
  localparam logic [15:0] CHAR16 = 16'(CHAR_CYC);
  localparam logic [15:0] TMO16 = 16'(RSP_TIMEOUT);

  generate
    if (CHAR_CYC < 2 || GAP_CYC > 65535 || RSP_TIMEOUT < 1 || RSP_TIMEOUT > 65535)
    begin : g_bad
      $error("timing parameter out of range");
    end
  endgenerate

  mbps_mst_s r;
  mbps_mst_s n;

  // --------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------
  always_comb
  begin
    n = r;
    n.m2s_v = 1'b0;
    n.done  = 1'b0;
    // idle time since the last answer byte
    if (lnk.s2m_valid)
      n.gap = 16'h0000;
    else if (r.gap != GAP16)
      n.gap = r.gap + 16'h0001;
    case (r.st)
      MBPS_M_IDLE:
      begin
        if (req_i && r.gap == GAP16)
        begin
          n.cmd   = cmd_i;
          n.order = word_order_select_i;
          n.tx[0] = axis_i;
          n.tx[1] = cmd_i;
          n.tx[2] = addr_i[15:8];
          n.tx[3] = addr_i[7:0];
          n.tx_n  = 4'h6;
          if (cmd_i == `MBPS_CMD_WR16)
          begin
            n.tx[4] = wdata_i[15:8];
            n.tx[5] = wdata_i[7:0];
          end
          else if (cmd_i == `MBPS_CMD_WR32)
          begin
            n.tx[4] = 8'h00;
            n.tx[5] = 8'h02;
            n.tx[6] = `MBPS_W32_BYTES;
            n.tx[7]  = word_order_select_i ? wdata_i[15:8] : wdata_i[31:24];
            n.tx[8]  = word_order_select_i ? wdata_i[7:0] : wdata_i[23:16];
            n.tx[9]  = word_order_select_i ? wdata_i[31:24] : wdata_i[15:8];
            n.tx[10] = word_order_select_i ? wdata_i[23:16] : wdata_i[7:0];
            n.tx_n  = 4'hB;
          end
          else
          begin
            n.tx[4] = count_i[15:8];
            n.tx[5] = count_i[7:0];
          end
          n.tx_i = 4'h0;
          n.tick = 16'h0000;
          n.crc  = `MBPS_CRC_INIT;
          {n.ok, n.exc, n.crc_err, n.timeout} = 4'h0;
          n.st   = MBPS_M_TX;
        end
      end
      MBPS_M_TX:
      begin
        if (r.tick != 16'h0000)
          n.tick = r.tick - 16'h0001;
        else
        begin
          n.tick  = CHAR16 - 16'h0001;
          n.m2s_v = 1'b1;
          n.tx_i  = r.tx_i + 4'h1;
          if (r.tx_i < r.tx_n)
          begin
            n.m2s_d = r.tx[r.tx_i];
            n.crc   = mbps_crc_step(r.crc, r.tx[r.tx_i]);
          end
          else if (r.tx_i == r.tx_n)
            n.m2s_d = r.crc[7:0];
          else
          begin
            n.m2s_d = r.crc[15:8];
            n.rx_n  = 4'h0;
            n.tmo   = 16'h0000;
            n.gap   = 16'h0000;
            n.crc   = `MBPS_CRC_INIT;
            n.st    = MBPS_M_RX;
          end
        end
      end
      MBPS_M_RX:
      begin
        if (lnk.s2m_valid)
        begin
          if (r.rx_n != 4'h9)
          begin
            n.rx[r.rx_n] = lnk.s2m_data;
            n.rx_n = r.rx_n + 4'h1;
          end
          n.crc = mbps_crc_step(r.crc, lnk.s2m_data);
        end
        else if (r.rx_n != 4'h0 && r.gap == GAP16)
        begin
          n.done = 1'b1;
          n.st   = MBPS_M_IDLE;
          if (r.crc != 16'h0000)
            n.crc_err = 1'b1;
          else if (r.rx[1][7])
          begin
            n.exc      = 1'b1;
            n.exc_code = r.rx[2];
          end
          else
          begin
            n.ok = 1'b1;
            if (r.cmd == `MBPS_CMD_READ && r.rx[2] == `MBPS_W32_BYTES)
              n.rdata = r.order ? {r.rx[5], r.rx[6], r.rx[3], r.rx[4]}
                                : {r.rx[3], r.rx[4], r.rx[5], r.rx[6]};
            else if (r.cmd == `MBPS_CMD_READ)
              n.rdata = {16'h0000, r.rx[3], r.rx[4]};
          end
        end
        else if (r.rx_n == 4'h0)
        begin
          // silence means the slave dropped or ignored the request
          n.tmo = r.tmo + 16'h0001;
          if (r.tmo == TMO16 - 16'h0001)
          begin
            n.done    = 1'b1;
            n.timeout = 1'b1;
            n.st      = MBPS_M_IDLE;
          end
        end
      end
      default:
        n.st = MBPS_M_IDLE;
    endcase
  end

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      r <= '0;
      r.st <= MBPS_M_IDLE;
      r.crc <= `MBPS_CRC_INIT;
    end
    else
      r <= n;
  end

  // --------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------
  assign lnk.m2s_valid = r.m2s_v;
  assign lnk.m2s_data  = r.m2s_d;
  assign ready_o       = (r.st == MBPS_M_IDLE) && (r.gap == GAP16);
  assign done_o        = r.done;
  assign ok_o          = r.ok;
  assign exc_o         = r.exc;
  assign exc_code_o    = r.exc_code;
  assign crc_err_o     = r.crc_err;
  assign timeout_o     = r.timeout;
  assign rdata_o       = r.rdata;
endmodule
`default_nettype wire

// ==== tb/mbps_monitor.sv ====
/*
  Checker of the byte link between host and slave ends.
  Assumes one clock and the slave answering to AXIS only.
*/
`default_nettype none
module mbps_monitor #(
  parameter int         GAP  = 56,
  parameter logic [7:0] AXIS = 8'h2A
)(
  input wire logic       clk_i,
  input wire logic       rstn_i,
  input wire logic       m2s_valid,
  input wire logic [7:0] m2s_data,
  input wire logic       s2m_valid,
  input wire logic [7:0] s2m_data
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // ------------------------------------------------------------------
  // frame trackers
  // ------------------------------------------------------------------
  logic [15:0] qm, qs, crc;
  logic [4:0]  n;
  logic [7:0]  rc, sc, b2;
  logic        m1;
  wire sfirst = (qs >= GAP);
  wire mfirst = (qm >= GAP);
  wire fend   = (qs == GAP);
  // own copy of the check step, kept apart from the design's
  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] d);
    c = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++)
    begin
      c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction
  // idle counts saturate just past the gap so a frame end shows once
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      qm <= 16'(GAP + 1);
      qs <= 16'(GAP + 1);
      n  <= 5'h00;
    end
    else
    begin
      qm <= m2s_valid ? 16'h0000 : (mfirst && qm > GAP ? qm : qm + 16'h0001);
      qs <= s2m_valid ? 16'h0000 : (sfirst && qs > GAP ? qs : qs + 16'h0001);
      m1 <= m2s_valid ? mfirst : m1;
      if (m2s_valid && !mfirst && m1)
        rc <= m2s_data;
      if (s2m_valid)
      begin
        n   <= sfirst ? 5'h01 : n + 5'h01;
        crc <= crc_upd(sfirst ? 16'hFFFF : crc, s2m_data);
        if (!sfirst && n == 5'h01)
          sc <= s2m_data;
        if (!sfirst && n == 5'h02)
          b2 <= s2m_data;
      end
    end
  end
  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  sequence s_quiet;
    !s2m_valid [*8];
  endsequence
  a_slave_addr_first: assert property (s2m_valid && sfirst |-> s2m_data == AXIS)
    else $error("answer does not start with own axis address");
  a_answer_after_gap: assert property (s2m_valid |-> qm >= GAP)
    else $error("answer started before the request gap");
  a_host_waits_gap: assert property (m2s_valid |-> qs >= GAP)
    else $error("request started before the answer gap");
  a_byte_spacing: assert property (s2m_valid |=> s_quiet)
    else $error("answer bytes too close together");
  a_cmd_echo: assert property (s2m_valid && !sfirst && n == 5'h01 |-> (s2m_data & 8'h7F) == rc)
    else $error("answer command does not echo request");
  a_crc_residue: assert property (fend |-> crc == 16'h0000)
    else $error("answer frame check wrong");
  a_err_frame_shape: assert property (fend && sc[7] |-> n == 5'h05 && b2 >= 8'h01 && b2 <= 8'h04)
    else $error("error frame malformed");
  a_read_len: assert property (fend && sc == 8'h03 |-> n == 5'(b2) + 5'h05)
    else $error("read answer length wrong");
  a_write_len: assert property (fend && (sc == 8'h06 || sc == 8'h10) |-> n == 5'h08)
    else $error("write answer length wrong");
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
/*
  Testbench: host and slave ends joined by the link; the bench drives
  host requests and plays the parameter store.
  Assumes the design defaults for character time and gap.
*/
`default_nettype none
module testbench;
  import mbps_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] AX = 8'h2A;
  logic clk_i = 1'b0, rstn_i = 1'b0, req = 1'b0, ord = 1'b0, ack = 1'b0;
  logic [7:0] cmd = 8'h00, axis = 8'h00, st = 8'h00, ecode, b3;
  logic [15:0] addr = 16'h0000, cnt = 16'h0000, pa, sa;
  logic [31:0] wdata = 32'h0, rd = 32'h0, rdata, pd, sd;
  logic ready, done, ok, exc, cerr, tmo, preq, pwe, pwide, sw, sv, got;
  int fail_count = 0, total_checks = 0, nb;
  mbps_link_if lnk();
  mbps_master #(.RSP_TIMEOUT(600)) i_mbps_master (.clk_i(clk_i), .rstn_i(rstn_i), .lnk(lnk), .req_i(req),
    .cmd_i(cmd), .axis_i(axis), .addr_i(addr), .count_i(cnt), .wdata_i(wdata), .word_order_select_i(ord),
    .ready_o(ready), .done_o(done), .ok_o(ok), .exc_o(exc), .exc_code_o(ecode), .crc_err_o(cerr),
    .timeout_o(tmo), .rdata_o(rdata));
  mbps_slave i_mbps_slave (.clk_i(clk_i), .rstn_i(rstn_i), .lnk(lnk), .axis_addr_i(AX),
    .word_order_select_i(ord), .param_req_o(preq), .param_we_o(pwe), .param_wide_o(pwide),
    .param_addr_o(pa), .param_wdata_o(pd), .param_ack_i(ack), .param_rdata_i(rd), .param_status_i(st));
  mbps_monitor #(.AXIS(AX)) i_mbps_monitor (.clk_i(clk_i), .rstn_i(rstn_i), .m2s_valid(lnk.m2s_valid),
    .m2s_data(lnk.m2s_data), .s2m_valid(lnk.s2m_valid), .s2m_data(lnk.s2m_data));
  // 200 MHz clock
  always #2.5 clk_i = ~clk_i;
  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one host request; the store acks once with rd and st
  task automatic xfer(input logic [7:0] c, a, input logic [15:0] ad, ct, input logic [31:0] wd);
    int k;
    k = 0;
    nb = 0;
    got = 1'b0;
    while (ready !== 1'b1 && k < 3000)
    begin
      @(negedge clk_i);
      k++;
    end
    {cmd, axis, addr, cnt, wdata, req} = {c, a, ad, ct, wd, 1'b1};
    @(negedge clk_i);
    req = 1'b0;
    while (done !== 1'b1 && k < 6000)
    begin
      ack = (preq === 1'b1 && !got);
      if (ack)
        {got, sw, sv, sa, sd} = {1'b1, pwe, pwide, pa, pd};
      // keep the first data byte of the answer to see the wire order
      if (lnk.s2m_valid === 1'b1)
      begin
        if (nb == 3)
          b3 = lnk.s2m_data;
        nb++;
      end
      @(negedge clk_i);
      k++;
    end
    ack = 1'b0;
    if (k >= 6000)
    begin
      fail_count++;
      report_and_stop();
    end
  endtask
  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_read16();
    {rd, st} = {32'h0000FF9C, 8'h00};
    xfer(8'h03, AX, 16'h0202, 16'h0001, 32'h0);
    chk("rd16 ok", 2, {ok, cerr});
    chk("rd16 access", {16'h0000, 16'h0202}, {14'h0, sw, sv, sa});
    chk("rd16 data", 32'h0000FF9C, rdata);
  endtask
  task automatic t_read32();
    for (int o = 0; o < 2; o++)
    begin
      {ord, rd, st} = {o[0], 32'h40000000, 8'h00};
      xfer(8'h03, AX, 16'h110C, 16'h0002, 32'h0);
      chk("rd32 wide", 1, sv);
      chk("rd32 data", 32'h40000000, rdata);
      chk("rd32 wire", o ? 32'h00 : 32'h40, {24'h0, b3});
    end
  endtask
  task automatic t_wr16();
    st = 8'h00;
    xfer(8'h06, AX, 16'h0202, 16'h0000, 32'h0002);
    chk("wr16 ok", 1, ok);
    chk("wr16 access", {16'h0202, 16'h0002}, {sa, sd[15:0]});
    chk("wr16 kind", 2, {sw, sv});
  endtask
  task automatic t_wr32();
    for (int o = 0; o < 2; o++)
    begin
      {ord, st} = {o[0], 8'h00};
      xfer(8'h10, AX, 16'h110C, 16'h0002, o ? 32'hFFFFFF9C : 32'h12345678);
      chk("wr32 ok kind", 7, {ok, sw, sv});
      chk("wr32 data", o ? 32'hFFFFFF9C : 32'h12345678, sd);
    end
  endtask
  task automatic t_errors();
    for (int s = 2; s < 5; s++)
    begin
      st = s[7:0];
      xfer(8'h03, AX, 16'h0202, 16'h0001, 32'h0);
      chk("err flags", 1, {ok, exc});
      chk("err code", s, ecode);
    end
    st = 8'h00;
    xfer(8'h2B, AX, 16'h0202, 16'h0001, 32'h0);
    chk("bad cmd", {1'b1, 8'h01, 1'b0}, {exc, ecode, got});
  endtask
  task automatic t_foreign();
    xfer(8'h03, AX + 8'h01, 16'h0202, 16'h0001, 32'h0);
    chk("foreign silent", 2, {tmo, got});
  endtask
  // reset for 16 cycles, then every scenario in turn
  initial
  begin
    repeat (16) @(negedge clk_i);
    rstn_i = 1'b1;
    t_read16();
    t_read32();
    t_wr16();
    t_wr32();
    t_errors();
    t_foreign();
    report_and_stop();
  end
endmodule
`default_nettype wire
